/* File: clg_pkg.sv */
package clg_pkg;

  // ==========================================================
  // Register offsets
  localparam logic [11:0] CLG_OFS_MODE = 12'h034;
  localparam logic [11:0] CLG_OFS_LOAD_A = 12'h038;
  localparam logic [11:0] CLG_OFS_LOAD_B = 12'h03C;
  localparam logic [11:0] CLG_OFS_CMD = 12'h0C0;
  localparam logic [11:0] CLG_OFS_STAT = 12'h0C4;
  localparam logic [11:0] CLG_OFS_COUNT = 12'h0C8;
  localparam logic [11:0] CLG_OFS_CFG = 12'h0CC;

  // ==========================================================
  // Reset values and counter limits
  localparam logic [15:0] CLG_MODE_RST = 16'h0000;
  localparam logic [31:0] CLG_LOAD_RST = 32'h0000_0000;
  localparam logic [1:0] CLG_CFG_RST = 2'h0;
  localparam logic [31:0] CLG_CNT_MAX = 32'hFFFF_FFFF;
  localparam logic [31:0] CLG_CNT_MIN = 32'h0000_0000;
  localparam logic [31:0] CLG_CNT_ONE = 32'h0000_0001;

  // ==========================================================
  // Command bits (write) and status bits (read)
  localparam int unsigned CLG_CMD_ARM = 0;
  localparam int unsigned CLG_CMD_DISARM = 1;
  localparam int unsigned CLG_CMD_LOAD = 2;
  localparam int unsigned CLG_CMD_BANK = 3;
  localparam int unsigned CLG_ST_ARMED = 0;
  localparam int unsigned CLG_ST_COUNTING = 1;
  localparam int unsigned CLG_ST_OUT = 2;
  localparam int unsigned CLG_ST_BANK = 3;
  localparam int unsigned CLG_ST_PEND = 4;

  // ==========================================================
  // Field codes
  localparam logic [1:0] CLG_GATE_OFF = 2'h0;
  localparam logic [1:0] CLG_GATE_LEVEL = 2'h1;
  localparam logic [1:0] CLG_GATE_RISE = 2'h2;
  localparam logic [1:0] CLG_GATE_FALL = 2'h3;
  localparam logic [1:0] CLG_TRIG_START_STOP = 2'h0;
  localparam logic [1:0] CLG_TRIG_STOP_START = 2'h1;
  localparam logic [1:0] CLG_TRIG_START_ONLY = 2'h2;
  localparam logic [1:0] CLG_TRIG_NONE = 2'h3;
  localparam logic [1:0] CLG_STOP_FIRST_TC = 2'h1;
  localparam logic [1:0] CLG_STOP_SECOND_TC = 2'h2;
  localparam logic [1:0] CLG_OUT_PULSE = 2'h1;
  localparam logic [1:0] CLG_OUT_TOGGLE_TC = 2'h2;
  localparam logic [1:0] CLG_OUT_TOGGLE_ANY = 2'h3;

  // ==========================================================
  // Mode register layout, bit 15 first
  typedef struct packed {
    logic reload_bank_alternate;
    logic reload_at_gate;
    logic gate_invert;
    logic reload_at_terminal_count;
    logic [1:0] hardware_disarm_select;
    logic [1:0] output_type_select;
    logic initial_reload_bank_pick;
    logic [1:0] stop_condition_select;
    logic [1:0] edge_start_stop_select;
    logic dual_edge_gating;
    logic [1:0] gate_interpretation;
  } clg_mode_type;

  // Extra configuration bits
  typedef struct packed {
    logic gate_level_picks_bank;
    logic gate_sets_direction;
  } clg_cfg_type;

  // Register port request
  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } clg_bus_req_type;

endpackage

/* File: clg_counter.sv */
// Local design decision: strobed register access.
`timescale 1ns/1ps

module clg_counter (
  // Clock and reset
  input logic core_clk,
  input logic resetn,
  // Register port
  input clg_pkg::clg_bus_req_type bus_req,
  output logic [31:0] rd_data,
  // Selected gate and source
  input logic gate_pin,
  input logic source_pin,
  // Counter state
  output logic counter_out,
  output logic armed,
  output logic counting
);
  import clg_pkg::*;

  // ==========================================================
  // Helpers

  // Bank 0 is the first reload value, bank 1 the second
  function automatic logic [31:0] clg_pick(input logic sel, input logic [31:0] a,
                                           input logic [31:0] b);
    return sel ? b : a;
  endfunction

  function automatic logic clg_hit(input logic [11:0] addr, input logic [11:0] ofs);
    return addr == ofs;
  endfunction

  // ==========================================================
  // Declarations
  clg_mode_type mode_r;
  clg_cfg_type cfg_r;
  logic [31:0] load_a_r;
  logic [31:0] load_b_r;
  logic [31:0] count_r;
  logic [31:0] count_nxt;
  logic [31:0] rd_data_r;
  logic [1:0] gate_sync_r;
  logic [1:0] src_sync_r;
  logic gate_d_r;
  logic src_d_r;
  logic armed_r;
  logic counting_r;
  logic tc_seen_r;
  logic reload_pend_r;
  logic bank_r;
  logic out_r;
  logic wr_mode, wr_load_a, wr_load_b, wr_cmd, wr_cfg;
  logic cmd_arm, cmd_disarm, cmd_load, cmd_bank;
  logic gate_eff, gate_eff_d, g_rise, g_fall, src_edge;
  logic edge_mode, level_mode, active_edge;
  logic run, count_down, tc_hit, stop_tc, stop_gate, start_gate, hw_disarm;
  logic start_at_arm, reload_now, reload_sel, sw_sel, gate_evt;
  logic [31:0] term;

  // ==========================================================
  // Write decode
  assign wr_mode = bus_req.wr && clg_hit(bus_req.addr, CLG_OFS_MODE);
  assign wr_load_a = bus_req.wr && clg_hit(bus_req.addr, CLG_OFS_LOAD_A);
  assign wr_load_b = bus_req.wr && clg_hit(bus_req.addr, CLG_OFS_LOAD_B);
  assign wr_cmd = bus_req.wr && clg_hit(bus_req.addr, CLG_OFS_CMD);
  assign wr_cfg = bus_req.wr && clg_hit(bus_req.addr, CLG_OFS_CFG);
  assign cmd_arm = wr_cmd && bus_req.wdata[CLG_CMD_ARM];
  assign cmd_disarm = wr_cmd && bus_req.wdata[CLG_CMD_DISARM];
  assign cmd_load = wr_cmd && bus_req.wdata[CLG_CMD_LOAD];
  assign cmd_bank = wr_cmd && bus_req.wdata[CLG_CMD_BANK];

  // ==========================================================
  // Pin synchronisers; third flop only feeds edge detection
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      gate_sync_r <= 2'h0;
      src_sync_r <= 2'h0;
      gate_d_r <= 1'b0;
      src_d_r <= 1'b0;
    end else begin
      gate_sync_r <= {gate_sync_r[0], gate_pin};
      src_sync_r <= {src_sync_r[0], source_pin};
      gate_d_r <= gate_sync_r[1];
      src_d_r <= src_sync_r[1];
    end
  end

  // ==========================================================
  // Gate interpretation
  assign gate_eff = gate_sync_r[1] ^ mode_r.gate_invert;
  assign gate_eff_d = gate_d_r ^ mode_r.gate_invert;
  assign g_rise = gate_eff && !gate_eff_d;
  assign g_fall = !gate_eff && gate_eff_d;
  assign src_edge = src_sync_r[1] && !src_d_r;
  assign edge_mode = (mode_r.gate_interpretation == CLG_GATE_RISE)
                  || (mode_r.gate_interpretation == CLG_GATE_FALL);
  assign level_mode = mode_r.gate_interpretation == CLG_GATE_LEVEL;

  // Active gate edge; level mode reports assertion for reload use
  always_comb begin
    unique case (mode_r.gate_interpretation)
      CLG_GATE_RISE: active_edge = g_rise || (mode_r.dual_edge_gating && g_fall);
      CLG_GATE_FALL: active_edge = g_fall;
      CLG_GATE_LEVEL: active_edge = g_rise;
      default: active_edge = 1'b0;
    endcase
  end

  // ==========================================================
  // Count conditions
  // Direction from gate only when gating is off, so it never also gates
  assign count_down = cfg_r.gate_sets_direction
                   && (mode_r.gate_interpretation == CLG_GATE_OFF) && gate_eff;
  assign term = count_down ? CLG_CNT_MIN : CLG_CNT_MAX;
  assign run = armed_r && counting_r && (!level_mode || gate_eff);
  assign tc_hit = src_edge && run && (count_r == term);

  // Stop on TC only in codes 1 and 2; code 3 falls back to gate only
  assign stop_tc = tc_hit && counting_r
                && ((mode_r.stop_condition_select == CLG_STOP_FIRST_TC)
                 || ((mode_r.stop_condition_select == CLG_STOP_SECOND_TC)
                  && tc_seen_r));

  // Gate stop and start; code 3 never starts or stops in edge modes, level mode stops on gate fall whatever the code
  assign stop_gate = armed_r && counting_r
                  && ((edge_mode && active_edge
                       && ((mode_r.edge_start_stop_select == CLG_TRIG_START_STOP)
                        || (mode_r.edge_start_stop_select == CLG_TRIG_STOP_START)))
                   || (level_mode && g_fall));
  assign start_gate = armed_r && !counting_r && edge_mode && active_edge
                   && (mode_r.edge_start_stop_select != CLG_TRIG_NONE);
  assign start_at_arm = !edge_mode
                     || (mode_r.edge_start_stop_select == CLG_TRIG_STOP_START)
                     || (mode_r.edge_start_stop_select == CLG_TRIG_NONE);
  // Bit 0 of the field disarms on TC, bit 1 on gate
  assign hw_disarm = (stop_tc && mode_r.hardware_disarm_select[0])
                  || (stop_gate && mode_r.hardware_disarm_select[1]);

  // ==========================================================
  // Reload source selection
  assign reload_sel = cfg_r.gate_level_picks_bank ? !gate_eff : bank_r;
  assign sw_sel = armed_r ? bank_r : mode_r.initial_reload_bank_pick;
  assign reload_now = src_edge
                   && (reload_pend_r || (tc_hit && mode_r.reload_at_terminal_count));
  assign gate_evt = armed_r && active_edge;

  // ==========================================================
  // Configuration registers, write only except the extra bits
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      mode_r <= CLG_MODE_RST;
    end else if (wr_mode) begin
      mode_r <= bus_req.wdata[15:0];
      // Bank pick is frozen while armed
      if (armed_r) begin
        mode_r.initial_reload_bank_pick <= mode_r.initial_reload_bank_pick;
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      load_a_r <= CLG_LOAD_RST;
      load_b_r <= CLG_LOAD_RST;
    end else begin
      if (wr_load_a) begin
        load_a_r <= bus_req.wdata;
      end
      if (wr_load_b) begin
        load_b_r <= bus_req.wdata;
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cfg_r <= CLG_CFG_RST;
    end else if (wr_cfg) begin
      cfg_r <= bus_req.wdata[1:0];
    end
  end

  // ==========================================================
  // Arm state; a disarm in the same write beats arm
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      armed_r <= 1'b0;
    end else if (cmd_disarm || hw_disarm) begin
      armed_r <= 1'b0;
    end else if (cmd_arm) begin
      armed_r <= 1'b1;
    end
  end

  // Counting state from arm, gate edges and terminal count
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      counting_r <= 1'b0;
    end else if (cmd_disarm || hw_disarm) begin
      counting_r <= 1'b0;
    end else if (cmd_arm && !armed_r) begin
      counting_r <= start_at_arm;
    end else if (stop_tc || stop_gate) begin
      counting_r <= 1'b0;
    end else if (start_gate) begin
      counting_r <= 1'b1;
    end
  end

  // First TC since counting began, for stop on second TC
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      tc_seen_r <= 1'b0;
    end else if ((cmd_arm && !armed_r) || start_gate) begin
      tc_seen_r <= 1'b0;
    end else if (tc_hit) begin
      tc_seen_r <= 1'b1;
    end
  end

  // Gate reload waits for the next source edge; a new request beats consumption
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      reload_pend_r <= 1'b0;
    end else if (mode_r.reload_at_gate && armed_r
                 && ((mode_r.edge_start_stop_select == CLG_TRIG_NONE)
                     ? active_edge : stop_gate)) begin
      reload_pend_r <= 1'b1;
    end else if (src_edge || cmd_disarm) begin
      reload_pend_r <= 1'b0;
    end
  end

  // ==========================================================
  // Bank selection
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      bank_r <= 1'b0;
    end else if (cmd_arm && !armed_r) begin
      bank_r <= mode_r.initial_reload_bank_pick;
    end else if (cmd_bank) begin
      bank_r <= !bank_r;
    end else if (reload_now && mode_r.reload_bank_alternate
                 && !cfg_r.gate_level_picks_bank) begin
      bank_r <= !bank_r;
    end
  end

  // ==========================================================
  // Counter; software load beats the source edge
  always_comb begin
    count_nxt = count_r;
    if (cmd_load) begin
      count_nxt = clg_pick(sw_sel, load_a_r, load_b_r);
    end else if (reload_now) begin
      count_nxt = clg_pick(reload_sel, load_a_r, load_b_r);
    end else if (src_edge && run) begin
      // Plain wrap at terminal count when reload on TC is off
      count_nxt = count_down ? count_r - CLG_CNT_ONE : count_r + CLG_CNT_ONE;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      count_r <= CLG_LOAD_RST;
    end else begin
      count_r <= count_nxt;
    end
  end

  // ==========================================================
  // Output waveform; reserved code holds it low
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      out_r <= 1'b0;
    end else begin
      unique case (mode_r.output_type_select)
        CLG_OUT_PULSE: out_r <= tc_hit;
        CLG_OUT_TOGGLE_TC: out_r <= out_r ^ tc_hit;
        CLG_OUT_TOGGLE_ANY: out_r <= out_r ^ (tc_hit || gate_evt);
        default: out_r <= 1'b0;
      endcase
    end
  end

  // ==========================================================
  // Read port; write-only and unmapped offsets read zero
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rd_data_r <= 32'h0000_0000;
    end else if (bus_req.rd) begin
      rd_data_r <= 32'h0000_0000;
      if (clg_hit(bus_req.addr, CLG_OFS_STAT)) begin
        rd_data_r[CLG_ST_ARMED] <= armed_r;
        rd_data_r[CLG_ST_COUNTING] <= counting_r;
        rd_data_r[CLG_ST_OUT] <= out_r;
        rd_data_r[CLG_ST_BANK] <= bank_r;
        rd_data_r[CLG_ST_PEND] <= reload_pend_r;
      end else if (clg_hit(bus_req.addr, CLG_OFS_COUNT)) begin
        rd_data_r <= count_r;
      end else if (clg_hit(bus_req.addr, CLG_OFS_CFG)) begin
        rd_data_r[1:0] <= cfg_r;
      end
    end else begin
      rd_data_r <= 32'h0000_0000;
    end
  end

  assign rd_data = rd_data_r;
  assign counter_out = out_r;
  assign armed = armed_r;
  assign counting = counting_r;

endmodule

/* File: clg_chk.sv */
`timescale 1ns/1ps
module clg_chk (
  // Clock and reset
  input logic core_clk,
  input logic resetn,
  // Register port
  input clg_pkg::clg_bus_req_type bus_req,
  input logic [31:0] rd_data,
  // Selected gate and source
  input logic gate_pin,
  input logic source_pin,
  // Counter state
  input logic counter_out,
  input logic armed,
  input logic counting
);
  import clg_pkg::*;
  clg_mode_type mode_r;
  logic src_q_r;
  logic [3:0] src_age_r;
  logic cmd_dis;

  // ==========================================================
  // Helper state
  // Shadow of the mode register, which cannot be read back
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn)
      mode_r <= CLG_MODE_RST;
    else if (bus_req.wr && bus_req.addr == CLG_OFS_MODE)
      mode_r <= bus_req.wdata[15:0];
  end

  // Cycles since the source pin last rose, saturating
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      src_q_r <= 1'b0;
      src_age_r <= 4'hF;
    end else begin
      src_q_r <= source_pin;
      if (source_pin && !src_q_r)
        src_age_r <= 4'h0;
      else if (src_age_r != 4'hF)
        src_age_r <= src_age_r + 4'h1;
    end
  end

  // Software disarm command
  assign cmd_dis = bus_req.wr && bus_req.addr == CLG_OFS_CMD && bus_req.wdata[CLG_CMD_DISARM];

  // ==========================================================
  // Properties
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  sequence s_rd(logic [11:0] ofs);
    bus_req.rd && bus_req.addr == ofs;
  endsequence

  sequence s_pulse_rise;
    $rose(counter_out) && mode_r.output_type_select == CLG_OUT_PULSE;
  endsequence

  property p_wo(logic [11:0] ofs);
    s_rd(ofs) |=> rd_data == 32'h0000_0000;
  endproperty

  a_mode_wo: assert property (p_wo(CLG_OFS_MODE))
    else $error("mode register read back nonzero");
  a_loadb_wo: assert property (p_wo(CLG_OFS_LOAD_B))
    else $error("second reload value read back nonzero");
  a_loada_wo: assert property (p_wo(CLG_OFS_LOAD_A))
    else $error("first reload value read back nonzero");
  a_pulse_one: assert property (s_pulse_rise |=> !counter_out)
    else $error("terminal count pulse longer than one cycle");
  a_out_src: assert property ($changed(counter_out) && mode_r.output_type_select inside {2'h1, 2'h2}
    && $stable(mode_r.output_type_select) |-> src_age_r <= 4'h7)
    else $error("output changed with no recent source edge");
  a_out_reserved: assert property (mode_r.output_type_select == 2'h0
    && $past(mode_r.output_type_select) == 2'h0 |-> !counter_out)
    else $error("reserved output type drove output high");
  a_no_hw_disarm: assert property ($fell(armed) && mode_r.hardware_disarm_select == 2'h0
    |-> $past(cmd_dis))
    else $error("hardware disarm while disarm field is zero");
  a_gate_off_run: assert property ($fell(counting) && mode_r.gate_interpretation == CLG_GATE_OFF
    && mode_r.stop_condition_select == 2'h0 && mode_r.hardware_disarm_select == 2'h0
    |-> $past(cmd_dis))
    else $error("counting stopped by gate with gating off");
endmodule

bind clg_counter clg_chk u_chk (.core_clk(core_clk), .resetn(resetn), .bus_req(bus_req),
  .rd_data(rd_data), .gate_pin(gate_pin), .source_pin(source_pin),
  .counter_out(counter_out), .armed(armed), .counting(counting));

/* File: clg_sig_model.sv */
`timescale 1ns/1ps
module clg_sig_model (
  // Clock
  input logic core_clk,
  // Selected gate and source
  output logic gate_pin,
  output logic source_pin
);
  initial begin
    gate_pin = 1'b0;
    source_pin = 1'b0;
  end

  // Source pulses held two clocks high and two low, so none is lost in sync
  task automatic pulse(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge core_clk);
      source_pin <= 1'b1;
      repeat (2) @(posedge core_clk);
      source_pin <= 1'b0;
      @(posedge core_clk);
    end
  endtask

  // New gate level, then time for the synchronizer to settle
  task automatic set_gate(input logic v);
    @(posedge core_clk);
    gate_pin <= v;
    repeat (4) @(posedge core_clk);
  endtask
endmodule

/* File: testbench.sv */
`timescale 1ns/1ps
module testbench;
  import clg_pkg::*;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  clg_bus_req_type bus_req = '0;
  logic [31:0] rd_data;
  logic counter_out, armed, counting, gate_pin, source_pin;
  int mismatches = 0;
  int cmp_count = 0;

  // 40 MHz core clock
  always #12.5 core_clk = ~core_clk;

  clg_counter dut (.core_clk(core_clk), .resetn(resetn), .bus_req(bus_req), .rd_data(rd_data),
    .gate_pin(gate_pin), .source_pin(source_pin), .counter_out(counter_out),
    .armed(armed), .counting(counting));
  clg_sig_model sig (.core_clk(core_clk), .gate_pin(gate_pin), .source_pin(source_pin));

  // ==========================================================
  // Tasks
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    bus_req <= '{a, d, 1'b1, 1'b0};
    @(posedge core_clk);
    bus_req.wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rc(input logic [11:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    bus_req <= '{a, 32'h0000_0000, 1'b0, 1'b1};
    @(posedge core_clk);
    bus_req.rd <= 1'b0;
    @(negedge core_clk);
    chk(rd_data, exp);
  endtask

  task automatic cmd(input int b);
    wr(CLG_OFS_CMD, 32'h0000_0001 << b);
  endtask

  // Pulses, then room for sync and counter update
  task automatic run(input int n);
    sig.pulse(n);
    repeat (4) @(posedge core_clk);
  endtask

  task automatic wait_disarm();
    for (int i = 0; i < 64 && armed !== 1'b0; i++) @(posedge core_clk);
    if (armed !== 1'b0) begin
      mismatches++;
      wrap_up();
    end
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    repeat (16) @(posedge core_clk);
    resetn <= 1'b1;
    rc(CLG_OFS_STAT, 32'h0000_0000);
    wr(CLG_OFS_LOAD_A, 32'h0000_0100);
    wr(CLG_OFS_LOAD_B, 32'h0000_0200);
    wr(CLG_OFS_MODE, 32'h0000_0080);
    rc(CLG_OFS_MODE, 32'h0000_0000);
    rc(CLG_OFS_LOAD_A, 32'h0000_0000);
    rc(CLG_OFS_LOAD_B, 32'h0000_0000);
    rc(12'h0FC, 32'h0000_0000);
    $display("test write_only done");
    // Disarmed software load follows bit 7
    cmd(CLG_CMD_LOAD);
    rc(CLG_OFS_COUNT, 32'h0000_0200);
    wr(CLG_OFS_MODE, 32'h0000_0000);
    cmd(CLG_CMD_LOAD);
    rc(CLG_OFS_COUNT, 32'h0000_0100);
    $display("test bank_pick done");
    // Gating off with trigger code 3: free count rolls over
    wr(CLG_OFS_LOAD_A, 32'hFFFF_FFFD);
    wr(CLG_OFS_MODE, 32'h0000_0018);
    cmd(CLG_CMD_LOAD);
    cmd(CLG_CMD_ARM);
    run(4);
    rc(CLG_OFS_COUNT, 32'h0000_0001);
    rc(CLG_OFS_STAT, 32'h0000_0003);
    wr(CLG_OFS_MODE, 32'h0000_0098);
    cmd(CLG_CMD_DISARM);
    cmd(CLG_CMD_LOAD);
    rc(CLG_OFS_COUNT, 32'hFFFF_FFFD);
    $display("test rollover done");
    // Reload at terminal count from alternating banks, toggled output
    wr(CLG_OFS_LOAD_A, 32'hFFFF_FFFE);
    wr(CLG_OFS_LOAD_B, 32'h0000_0010);
    wr(CLG_OFS_MODE, 32'h0000_9218);
    cmd(CLG_CMD_LOAD);
    cmd(CLG_CMD_ARM);
    run(2);
    rc(CLG_OFS_COUNT, 32'hFFFF_FFFE);
    chk({31'h0, counter_out}, 32'h0000_0001);
    run(2);
    rc(CLG_OFS_COUNT, 32'h0000_0010);
    cmd(CLG_CMD_DISARM);
    $display("test tc_reload done");
    // Terminal count alone stops and disarms, pulse output
    wr(CLG_OFS_MODE, 32'h0000_0538);
    cmd(CLG_CMD_LOAD);
    cmd(CLG_CMD_ARM);
    run(3);
    wait_disarm();
    chk({31'h0, armed}, 32'h0000_0000);
    chk({31'h0, counting}, 32'h0000_0000);
    $display("test tc_stop done");
    // Level gating, plain then inverted gate
    wr(CLG_OFS_LOAD_A, 32'h0000_0000);
    for (int inv = 0; inv < 2; inv++) begin
      sig.set_gate(inv[0]);
      wr(CLG_OFS_MODE, {18'h0, inv[0], 13'h0001});
      cmd(CLG_CMD_LOAD);
      cmd(CLG_CMD_ARM);
      run(2);
      rc(CLG_OFS_COUNT, 32'h0000_0000);
      sig.set_gate(!inv[0]);
      run(2);
      rc(CLG_OFS_COUNT, 32'h0000_0002);
      cmd(CLG_CMD_DISARM);
    end
    $display("test level_gate done");
    // Rising edge gating, start then stop, reload on the stopping gate
    wr(CLG_OFS_LOAD_A, 32'h0000_0020);
    wr(CLG_OFS_MODE, 32'h0000_4302);
    cmd(CLG_CMD_LOAD);
    cmd(CLG_CMD_ARM);
    run(2);
    rc(CLG_OFS_COUNT, 32'h0000_0020);
    sig.set_gate(1'b1);
    run(2);
    rc(CLG_OFS_COUNT, 32'h0000_0022);
    chk({31'h0, counter_out}, 32'h0000_0001);
    sig.set_gate(1'b0);
    sig.set_gate(1'b1);
    run(1);
    rc(CLG_OFS_COUNT, 32'h0000_0020);
    rc(CLG_OFS_STAT, 32'h0000_0001);
    cmd(CLG_CMD_DISARM);
    $display("test edge_gate done");
    // Both edges: a falling gate starts counting
    wr(CLG_OFS_MODE, 32'h0000_0306);
    cmd(CLG_CMD_LOAD);
    cmd(CLG_CMD_ARM);
    sig.set_gate(1'b0);
    run(2);
    rc(CLG_OFS_COUNT, 32'h0000_0022);
    cmd(CLG_CMD_DISARM);
    $display("test both_edges done");
    // Gate sets direction with gating off; bank command while armed
    wr(CLG_OFS_CFG, 32'h0000_0001);
    rc(CLG_OFS_CFG, 32'h0000_0001);
    wr(CLG_OFS_LOAD_A, 32'h0000_0030);
    wr(CLG_OFS_MODE, 32'h0000_0018);
    sig.set_gate(1'b1);
    cmd(CLG_CMD_LOAD);
    cmd(CLG_CMD_ARM);
    run(2);
    rc(CLG_OFS_COUNT, 32'h0000_002E);
    cmd(CLG_CMD_BANK);
    cmd(CLG_CMD_LOAD);
    rc(CLG_OFS_COUNT, 32'h0000_0010);
    rc(CLG_OFS_STAT, 32'h0000_000B);
    cmd(CLG_CMD_DISARM);
    wr(CLG_OFS_CFG, 32'h0000_0000);
    $display("test direction_bank done");
    wrap_up();
  end
endmodule
